// ===== core/cbc_bridge_regs.sv
// Bridge configuration register group with AHB-Lite register access.
// Assumes one clock; query, abort and parity inputs come from logic on
// that clock, the card error pin comes from outside and is synchronised.
`timescale 1ns/1ps

// How it works
// - Interrupt pin reads 01h at reset; value follows function and mode.
// - Bridge control bits 15-11 and 4 always read zero.
// - Bit 10 enables burst write posting in both directions.
// - Bit 9 marks window 1 prefetchable, resets to one.
// - Bit 8 marks window 0 prefetchable, resets to one.
// - Bit 7 routes card interrupts to PCI lines or legacy IRQ.
// - Bit 6 holds card reset asserted; resets to one.
// - Bus reset also asserts card reset regardless of bit 6.
// - Bit 5 set turns card master abort into target abort, and into SERR when PCI SERR enable is set.
// - Bit 3 forwards VGA address ranges to the card.
// - Bit 2 withholds ISA alias I/O cycles from the card.
// - Bit 1 forwards card system error to PCI SERR.
// - Bit 0 reports card parity errors on the card parity line.
// - Subsystem codes reset zero; writable only with write enable set.
// - Legacy base decodes index port, base plus one data port.
// - Legacy base bits 31-1 writable, bit 0 reads one.
module cbc_bridge_regs #(
	parameter logic [7:0] FUNC_NUM = 8'h00
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Address query from the forwarding logic
	input wire logic i_qry_valid,
	input wire logic i_qry_is_io,
	input wire logic [31:0] i_qry_addr,
	output logic o_qry_done,
	output logic o_qry_forward,
	output logic o_qry_vga,
	output logic o_qry_legacy_index,
	output logic o_qry_legacy_data,
	// Card side events
	input wire logic i_card_master_abort,
	input wire logic i_card_parity_err,
	input wire logic i_card_serr_n,
	input wire logic i_pci_serr_enable,
	output logic o_pci_target_abort,
	output logic o_pci_serr,
	output logic o_card_perr,
	// Bridge control outputs
	output logic o_card_reset_n,
	output logic o_write_posting_enable,
	output logic o_window0_prefetchable,
	output logic o_window1_prefetchable,
	output logic o_func_irq_route_select,
	output logic [7:0] o_irq_pin,
	// Interrupt
	output logic o_irq
);
	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic in_range(input logic [31:0] a,
			input logic [31:0] lo, input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	function automatic logic is_vga(input logic io, input logic [31:0] a);
		if (io) begin
			is_vga = in_range(a, cbc_pkg::VGA_IO1_LO, cbc_pkg::VGA_IO1_HI) ||
				in_range(a, cbc_pkg::VGA_IO2_LO, cbc_pkg::VGA_IO2_HI);
		end else begin
			is_vga = in_range(a, cbc_pkg::VGA_MEM_LO, cbc_pkg::VGA_MEM_HI);
		end
	endfunction : is_vga

	function automatic logic is_isa_alias(input logic [31:0] a);
		is_isa_alias = (a[31:16] == cbc_pkg::ISA_PAGE) &&
			(a[9:8] != cbc_pkg::ISA_LOW_QUARTER);
	endfunction : is_isa_alias

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [31:0] wmask);
		merge = (old & ~wmask) | (wd & wmask);
	endfunction : merge

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_n_reg;

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	cbc_pkg::cbc_bus_e bus_state_reg;
	logic [9:0] addr_idx_reg;
	logic write_reg;
	logic [15:0] bridge_ctrl_reg;
	logic [15:0] subsys_vendor_reg;
	logic [15:0] subsys_reg;
	logic [31:0] legacy_base_reg;
	logic [1:0] irq_mode_reg;
	logic subsys_we_reg;
	logic [cbc_pkg::EV_W-1:0] irq_status_reg;
	logic [cbc_pkg::EV_W-1:0] irq_mask_reg;
	logic [cbc_pkg::EV_W-1:0] ev_set;
	logic [31:0] rd_mux;
	logic addr_phase;
	logic wr_go;
	logic rd_go;

	assign addr_phase = i_hsel && i_hready &&
		(i_htrans == cbc_pkg::HTRANS_NONSEQ);
	assign wr_go = (bus_state_reg == cbc_pkg::BS_DATA) && write_reg;
	assign rd_go = (bus_state_reg == cbc_pkg::BS_DATA) && !write_reg;

	// One wait state gives the read mux a full cycle into a flop
	always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			bus_state_reg <= cbc_pkg::BS_IDLE;
			addr_idx_reg <= 10'h000;
			write_reg <= 1'b0;
			o_hreadyout <= 1'b1;
		end else begin
			case (bus_state_reg)
			cbc_pkg::BS_IDLE: begin
				if (addr_phase) begin
					bus_state_reg <= cbc_pkg::BS_DATA;
					addr_idx_reg <= i_haddr[11:2];
					write_reg <= i_hwrite;
					o_hreadyout <= 1'b0;
				end
			end
			cbc_pkg::BS_DATA: begin
				bus_state_reg <= cbc_pkg::BS_IDLE;
				o_hreadyout <= 1'b1;
			end
			default: begin
				bus_state_reg <= cbc_pkg::BS_IDLE;
				o_hreadyout <= 1'b1;
			end
			endcase
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		case (addr_idx_reg)
		cbc_pkg::IDX_IRQ_PIN: rd_mux[7:0] = o_irq_pin;
		cbc_pkg::IDX_BRIDGE_CTRL: rd_mux[15:0] = bridge_ctrl_reg &
			cbc_pkg::BC_WMASK;
		cbc_pkg::IDX_SUBSYS_VENDOR: rd_mux[15:0] = subsys_vendor_reg;
		cbc_pkg::IDX_SUBSYS: rd_mux[15:0] = subsys_reg;
		cbc_pkg::IDX_LEGACY_BASE: rd_mux = legacy_base_reg |
			cbc_pkg::LEGACY_RESET;
		cbc_pkg::IDX_DEV_CTRL: rd_mux[cbc_pkg::DEV_MODE_LSB +: 2] =
			irq_mode_reg;
		cbc_pkg::IDX_SYS_CTRL: rd_mux[cbc_pkg::SYS_SUBSYS_WE] =
			subsys_we_reg;
		cbc_pkg::IDX_IRQ_STATUS: rd_mux[cbc_pkg::EV_W-1:0] = irq_status_reg;
		cbc_pkg::IDX_IRQ_MASK: rd_mux[cbc_pkg::EV_W-1:0] = irq_mask_reg;
		default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_hrdata <= 32'h00000000;
			o_hresp <= cbc_pkg::HRESP_OKAY;
		end else begin
			o_hresp <= cbc_pkg::HRESP_OKAY;
			if (rd_go) begin
				o_hrdata <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	logic [31:0] bc_merged;

	// Merge runs at word width; only the low half is kept below
	assign bc_merged = merge({16'h0000, bridge_ctrl_reg}, i_hwdata,
		{16'h0000, cbc_pkg::BC_WMASK});

	always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			bridge_ctrl_reg <= cbc_pkg::BC_RESET;
			legacy_base_reg <= cbc_pkg::LEGACY_RESET;
			irq_mode_reg <= cbc_pkg::MODE_SERIAL_ALL;
			subsys_we_reg <= cbc_pkg::SYS_SUBSYS_WE_RESET;
			irq_mask_reg <= '0;
		end else if (wr_go) begin
			case (addr_idx_reg)
			cbc_pkg::IDX_BRIDGE_CTRL: bridge_ctrl_reg <= bc_merged[15:0];
			// only bits 31-1 take the write
			cbc_pkg::IDX_LEGACY_BASE: legacy_base_reg <= merge(
				legacy_base_reg, i_hwdata, cbc_pkg::LEGACY_WMASK);
			cbc_pkg::IDX_DEV_CTRL: irq_mode_reg <=
				i_hwdata[cbc_pkg::DEV_MODE_LSB +: 2];
			cbc_pkg::IDX_SYS_CTRL: subsys_we_reg <=
				i_hwdata[cbc_pkg::SYS_SUBSYS_WE];
			cbc_pkg::IDX_IRQ_MASK: irq_mask_reg <=
				i_hwdata[cbc_pkg::EV_W-1:0];
			default: begin
			end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			subsys_vendor_reg <= cbc_pkg::SUBSYS_RESET;
			subsys_reg <= cbc_pkg::SUBSYS_RESET;
		end else if (wr_go && subsys_we_reg) begin
			if (addr_idx_reg == cbc_pkg::IDX_SUBSYS_VENDOR) begin
				subsys_vendor_reg <= i_hwdata[15:0];
			end
			if (addr_idx_reg == cbc_pkg::IDX_SUBSYS) begin
				subsys_reg <= i_hwdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Bridge control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			// bus reset holds the card in reset
			o_card_reset_n <= 1'b0;
			o_write_posting_enable <= 1'b0;
			o_window0_prefetchable <= 1'b1;
			o_window1_prefetchable <= 1'b1;
			o_func_irq_route_select <= 1'b0;
			o_irq_pin <= cbc_pkg::IRQ_PIN_RESET;
		end else begin
			o_card_reset_n <= !bridge_ctrl_reg[cbc_pkg::BC_CRST];
			o_write_posting_enable <= bridge_ctrl_reg[cbc_pkg::BC_POST];
			o_window0_prefetchable <= bridge_ctrl_reg[cbc_pkg::BC_PREF0];
			o_window1_prefetchable <= bridge_ctrl_reg[cbc_pkg::BC_PREF1];
			o_func_irq_route_select <= bridge_ctrl_reg[cbc_pkg::BC_ROUTE];
			if (irq_mode_reg == cbc_pkg::MODE_ISA_ONLY) begin
				o_irq_pin <= cbc_pkg::IRQ_PIN_NONE;
			end else begin
				o_irq_pin <= cbc_pkg::IRQ_PIN_RESET + FUNC_NUM;
			end
		end
	end

	// ----------------------------------------------------------------
	// Address query
	// ----------------------------------------------------------------
	logic [31:0] legacy_index_addr;
	logic isa_drop;

	assign legacy_index_addr = legacy_base_reg & cbc_pkg::LEGACY_WMASK;
	assign isa_drop = i_qry_valid && i_qry_is_io &&
		bridge_ctrl_reg[cbc_pkg::BC_ISA] && is_isa_alias(i_qry_addr);

	always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_qry_done <= 1'b0;
			o_qry_forward <= 1'b0;
			o_qry_vga <= 1'b0;
			o_qry_legacy_index <= 1'b0;
			o_qry_legacy_data <= 1'b0;
		end else begin
			o_qry_done <= i_qry_valid;
			o_qry_forward <= i_qry_valid && !isa_drop;
			o_qry_vga <= i_qry_valid && bridge_ctrl_reg[cbc_pkg::BC_VGA] &&
				is_vga(i_qry_is_io, i_qry_addr);
			o_qry_legacy_index <= i_qry_valid && i_qry_is_io &&
				(i_qry_addr == legacy_index_addr);
			o_qry_legacy_data <= i_qry_valid && i_qry_is_io &&
				(i_qry_addr == legacy_index_addr +
				cbc_pkg::LEGACY_DATA_STEP);
		end
	end

	// ----------------------------------------------------------------
	// Card error pin synchroniser
	// ----------------------------------------------------------------
	logic serr_s1_reg;
	logic serr_s2_reg;
	logic serr_s3_reg;
	logic serr_level_reg;
	logic cserr_rise;

	always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			serr_s1_reg <= 1'b0;
			serr_s2_reg <= 1'b0;
			serr_s3_reg <= 1'b0;
			serr_level_reg <= 1'b0;
		end else begin
			serr_s1_reg <= !i_card_serr_n;
			serr_s2_reg <= serr_s1_reg;
			serr_s3_reg <= serr_s2_reg;
			if (serr_s2_reg == serr_s3_reg) begin
				serr_level_reg <= serr_s3_reg;
			end
		end
	end

	assign cserr_rise = (serr_s2_reg == serr_s3_reg) && serr_s3_reg &&
		!serr_level_reg;

	// ----------------------------------------------------------------
	// Error reporting
	// ----------------------------------------------------------------
	logic mabt_report;

	// aborts raise target abort and SERR only when reporting is enabled; the status bit is set either way
	assign mabt_report = i_card_master_abort &&
		bridge_ctrl_reg[cbc_pkg::BC_MABT];

	always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_pci_target_abort <= 1'b0;
			o_pci_serr <= 1'b0;
			o_card_perr <= 1'b0;
		end else begin
			o_pci_target_abort <= mabt_report;
			o_pci_serr <= (mabt_report && i_pci_serr_enable) ||
				(cserr_rise && bridge_ctrl_reg[cbc_pkg::BC_CSERR]);
			o_card_perr <= i_card_parity_err &&
				bridge_ctrl_reg[cbc_pkg::BC_CPERR];
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	always_comb begin
		ev_set = '0;
		ev_set[cbc_pkg::EV_MABORT] = i_card_master_abort;
		ev_set[cbc_pkg::EV_CSERR] = cserr_rise;
		ev_set[cbc_pkg::EV_CPERR] = i_card_parity_err;
		ev_set[cbc_pkg::EV_ISA_DROP] = isa_drop;
	end

	// Set beats the read clear so no event is lost
	always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			irq_status_reg <= '0;
			o_irq <= 1'b0;
		end else begin
			if (rd_go && addr_idx_reg == cbc_pkg::IDX_IRQ_STATUS) begin
				irq_status_reg <= ev_set;
			end else begin
				irq_status_reg <= irq_status_reg | ev_set;
			end
			o_irq <= |(irq_status_reg & irq_mask_reg);
		end
	end
endmodule : cbc_bridge_regs

// ===== pkg/cbc_pkg.sv
// Constants shared by the bridge configuration register group.
// Assumes a 32-bit AHB-Lite slave where each register owns one word.
package cbc_pkg;
	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0] IDX_IRQ_PIN = 10'h03d;
	localparam logic [9:0] IDX_BRIDGE_CTRL = 10'h03e;
	localparam logic [9:0] IDX_SUBSYS_VENDOR = 10'h040;
	localparam logic [9:0] IDX_SUBSYS = 10'h042;
	localparam logic [9:0] IDX_LEGACY_BASE = 10'h044;
	localparam logic [9:0] IDX_DEV_CTRL = 10'h050;
	localparam logic [9:0] IDX_SYS_CTRL = 10'h051;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h052;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h053;

	// ----------------------------------------------------------------
	// Bridge control layout
	// ----------------------------------------------------------------
	localparam logic [15:0] BC_RESET = 16'h0340;
	localparam logic [15:0] BC_WMASK = 16'h07ef;
	localparam int BC_POST = 10;
	localparam int BC_PREF1 = 9;
	localparam int BC_PREF0 = 8;
	localparam int BC_ROUTE = 7;
	localparam int BC_CRST = 6;
	localparam int BC_MABT = 5;
	localparam int BC_VGA = 3;
	localparam int BC_ISA = 2;
	localparam int BC_CSERR = 1;
	localparam int BC_CPERR = 0;

	// ----------------------------------------------------------------
	// Other fields and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] IRQ_PIN_RESET = 8'h01;
	localparam logic [7:0] IRQ_PIN_NONE = 8'h00;
	localparam logic [15:0] SUBSYS_RESET = 16'h0000;
	localparam logic [31:0] LEGACY_RESET = 32'h00000001;
	localparam logic [31:0] LEGACY_WMASK = 32'hfffffffe;
	localparam int DEV_MODE_LSB = 1;
	localparam logic [1:0] MODE_ISA_ONLY = 2'h0;
	localparam logic [1:0] MODE_SERIAL_ALL = 2'h3;
	localparam int SYS_SUBSYS_WE = 5;
	localparam logic SYS_SUBSYS_WE_RESET = 1'b1;

	// ----------------------------------------------------------------
	// Event status bits
	// ----------------------------------------------------------------
	localparam int EV_W = 4;
	localparam int EV_MABORT = 0;
	localparam int EV_CSERR = 1;
	localparam int EV_CPERR = 2;
	localparam int EV_ISA_DROP = 3;

	// ----------------------------------------------------------------
	// Address decode constants
	// ----------------------------------------------------------------
	localparam logic [31:0] VGA_MEM_LO = 32'h000a0000;
	localparam logic [31:0] VGA_MEM_HI = 32'h000bffff;
	localparam logic [31:0] VGA_IO1_LO = 32'h000003b0;
	localparam logic [31:0] VGA_IO1_HI = 32'h000003bb;
	localparam logic [31:0] VGA_IO2_LO = 32'h000003c0;
	localparam logic [31:0] VGA_IO2_HI = 32'h000003df;
	localparam logic [15:0] ISA_PAGE = 16'h0000;
	localparam logic [1:0] ISA_LOW_QUARTER = 2'h0;
	localparam logic [31:0] LEGACY_DATA_STEP = 32'h00000001;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		BS_IDLE = 2'b01,
		BS_DATA = 2'b10
	} cbc_bus_e;
endpackage : cbc_pkg

// ===== verif/cbc_card_model.sv
// Card socket stand-in: abort and parity pulses, card system error pin.
// Runs on the system clock; the error pin idles high on its pull-up.
`timescale 1ns/1ps
module cbc_card_model (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Commands from the bench
	input wire logic i_do_abort,
	input wire logic i_do_perr,
	input wire logic i_do_serr,
	input wire logic [3:0] i_serr_len,
	// Card side
	output logic o_master_abort,
	output logic o_parity_err,
	output logic o_serr_n
);
	logic [3:0] cnt_reg;
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_master_abort <= 1'b0;
			o_parity_err <= 1'b0;
		end else begin
			o_master_abort <= i_do_abort;
			o_parity_err <= i_do_perr;
		end
	end
	// Pin held low for the asked length, then left to the pull-up
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b)
			cnt_reg <= 4'h0;
		else if (i_do_serr)
			cnt_reg <= i_serr_len;
		else if (cnt_reg != 4'h0)
			cnt_reg <= cnt_reg - 4'h1;
	end
	assign o_serr_n = (cnt_reg == 4'h0);
endmodule : cbc_card_model

// ===== verif/cbc_bridge_regs_asserts.sv
// Checker for the bridge configuration register group.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
module cbc_bridge_regs_asserts #(
	parameter logic [7:0] FUNC_NUM = 8'h00
) (
	// Clock, reset, bus
	input logic i_clk_sys,
	input logic i_rst_b,
	input logic i_hsel,
	input logic [31:0] i_haddr,
	input logic [1:0] i_htrans,
	input logic i_hwrite,
	input logic [31:0] i_hwdata,
	input logic i_hready,
	input logic o_hreadyout,
	input logic o_hresp,
	// Query and events
	input logic i_qry_valid,
	input logic i_qry_is_io,
	input logic [31:0] i_qry_addr,
	input logic o_qry_done,
	input logic o_qry_forward,
	input logic i_card_master_abort,
	input logic i_card_parity_err,
	input logic o_pci_target_abort,
	input logic o_pci_serr,
	input logic o_card_perr,
	// Control outputs
	input logic o_card_reset_n,
	input logic o_write_posting_enable,
	input logic o_window0_prefetchable,
	input logic o_window1_prefetchable,
	input logic o_func_irq_route_select,
	input logic [7:0] o_irq_pin,
	input logic o_irq
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);
	// --------
	// Helper
	// --------
	logic tk, wa_reg, wd_reg, we_reg;
	logic [31:0] bcw_reg;
	assign tk = i_hsel && i_hready && i_htrans == 2'h2;
	// Follow a control write to the edge that stores its data
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wa_reg <= 1'b0;
			wd_reg <= 1'b0;
			we_reg <= 1'b0;
			bcw_reg <= 32'h0;
		end else begin
			wa_reg <= tk && i_hwrite && i_haddr[11:2] == 10'h03e;
			wd_reg <= wa_reg;
			we_reg <= wd_reg;
			if (wd_reg)
				bcw_reg <= i_hwdata;
		end
	end
	property p_copy(o, b);
		we_reg |-> ##[0:1] (o == b);
	endproperty
	// --------
	// Assertions
	// --------
	a_resp_okay: assert property (o_hresp == 1'b0)
		else $error("response not okay");
	a_one_wait: assert property (tk |=> !o_hreadyout ##1 o_hreadyout)
		else $error("wait state wrong");
	a_post_copy: assert property (p_copy(o_write_posting_enable, bcw_reg[10]))
		else $error("posting enable wrong");
	a_win1_copy: assert property (p_copy(o_window1_prefetchable, bcw_reg[9]))
		else $error("window 1 type wrong");
	a_win0_copy: assert property (p_copy(o_window0_prefetchable, bcw_reg[8]))
		else $error("window 0 type wrong");
	a_route_copy: assert property (p_copy(o_func_irq_route_select, bcw_reg[7]))
		else $error("route select wrong");
	a_card_rst: assert property (p_copy(o_card_reset_n, !bcw_reg[6]))
		else $error("card reset wrong");
	a_abort_cause: assert property (o_pci_target_abort |-> $past(i_card_master_abort))
		else $error("target abort without cause");
	a_perr_cause: assert property (o_card_perr |-> $past(i_card_parity_err))
		else $error("parity report without cause");
	a_pin_value: assert property (o_irq_pin == 8'h00 || o_irq_pin == 8'h01 + FUNC_NUM)
		else $error("interrupt pin value wrong");
	a_qry_done: assert property (o_qry_done == $past(i_qry_valid))
		else $error("query done wrong");
	a_isa_pass: assert property (i_qry_valid && (!i_qry_is_io ||
		i_qry_addr[31:16] != 16'h0 || i_qry_addr[9:8] == 2'h0) |=> o_qry_forward)
		else $error("query withheld wrongly");
	a_isa_hold: assert property (i_qry_valid && i_qry_is_io && bcw_reg[2] &&
		i_qry_addr[31:16] == 16'h0 && i_qry_addr[9:8] != 2'h0 |=> !o_qry_forward)
		else $error("alias query forwarded");
	c_abort: cover property (o_pci_target_abort);
	c_serr: cover property (o_pci_serr);
	c_irq: cover property (o_irq);
	c_write: cover property (tk && i_hwrite);
endmodule : cbc_bridge_regs_asserts
bind cbc_bridge_regs cbc_bridge_regs_asserts #(.FUNC_NUM(FUNC_NUM)) u_chk (.*);

// ===== verif/cbc_bridge_regs_tb.sv
// Self-checking bench for the bridge configuration register group.
// Drives AHB-Lite, address queries and card events against a model.
`timescale 1ns/1ps
module cbc_bridge_regs_tb;
	// --------
	// Signals
	// --------
	logic i_clk_sys = 1'b0;
	logic i_rst_b = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic qv = 1'b0;
	logic qio = 1'b0;
	logic [31:0] qa = 32'h0;
	logic serr_en = 1'b0;
	logic do_ab = 1'b0;
	logic do_pe = 1'b0;
	logic do_se = 1'b0;
	logic [3:0] se_len = 4'h3;
	logic [31:0] hrdata;
	logic hreadyout, hresp, q_done, q_fwd, q_vga, q_idx, q_dat;
	logic m_ab, p_err, serr_n, ta, pserr, cperr, crst_n;
	logic post, pref0, pref1, route, irq;
	logic [7:0] irq_pin;
	int failures = 0;
	int checks_done = 0;
	int seed = 32'hf5a4;
	logic [15:0] m_bc, m_sv, m_ss;
	logic [31:0] m_lb;
	logic [1:0] m_mode;
	logic m_we;
	logic [3:0] m_st, m_mask;
	logic [31:0] regs [8] = '{32'hf4, 32'hf8, 32'h100, 32'h108,
		32'h110, 32'h148, 32'h14c, 32'h1fc};
	logic [31:0] qtab [8] = '{32'h100, 32'h10, 32'h3c0, 32'h3b4,
		32'ha0000, 32'hbfffc, 32'h10300, 32'h3ff};
	always #50 i_clk_sys = ~i_clk_sys;
	cbc_bridge_regs dut_u (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
		.i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hreadyout), .o_hrdata(hrdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .i_qry_valid(qv),
		.i_qry_is_io(qio), .i_qry_addr(qa), .o_qry_done(q_done),
		.o_qry_forward(q_fwd), .o_qry_vga(q_vga),
		.o_qry_legacy_index(q_idx), .o_qry_legacy_data(q_dat),
		.i_card_master_abort(m_ab), .i_card_parity_err(p_err),
		.i_card_serr_n(serr_n), .i_pci_serr_enable(serr_en),
		.o_pci_target_abort(ta), .o_pci_serr(pserr), .o_card_perr(cperr),
		.o_card_reset_n(crst_n), .o_write_posting_enable(post),
		.o_window0_prefetchable(pref0), .o_window1_prefetchable(pref1),
		.o_func_irq_route_select(route), .o_irq_pin(irq_pin), .o_irq(irq));
	cbc_card_model u_card (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
		.i_do_abort(do_ab), .i_do_perr(do_pe), .i_do_serr(do_se),
		.i_serr_len(se_len), .o_master_abort(m_ab),
		.o_parity_err(p_err), .o_serr_n(serr_n));
	// --------
	// Tasks
	// --------
	task automatic close_out;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			failures++;
			close_out();
		end
	endtask : wait_rdy
	task automatic ahb(input logic w, input logic [31:0] a, d,
			output logic [31:0] r);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
	endtask : ahb
	function automatic logic [31:0] expv(input logic [31:0] a);
		case (a)
			32'hf4: return (m_mode == 2'h0) ? 32'h0 : 32'h1;
			32'hf8: return {16'h0, m_bc};
			32'h100: return {16'h0, m_sv};
			32'h108: return {16'h0, m_ss};
			32'h110: return m_lb;
			32'h148: return {28'h0, m_st};
			32'h14c: return {28'h0, m_mask};
			default: return 32'h0;
		endcase
	endfunction : expv
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		case (a)
			32'hf8: m_bc = d[15:0] & 16'h07ef;
			32'h100: if (m_we) m_sv = d[15:0];
			32'h108: if (m_we) m_ss = d[15:0];
			32'h110: m_lb = {d[31:1], 1'b1};
			32'h140: m_mode = d[2:1];
			32'h144: m_we = d[5];
			32'h14c: m_mask = d[3:0];
			default: ;
		endcase
		ahb(1'b1, a, d, r);
	endtask : wr
	task automatic rc(input logic [31:0] a);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk(r, expv(a));
		if (a == 32'h148)
			m_st = 4'h0;
	endtask : rc
	task automatic outs;
		repeat (2) @(posedge i_clk_sys);
		chk({27'h0, post, pref1, pref0, route, crst_n},
			{27'h0, m_bc[10:7], !m_bc[6]});
	endtask : outs
	task automatic qry(input logic io, input logic [31:0] a);
		logic drop, vga;
		logic [31:0] ix;
		drop = io && m_bc[2] && a[31:16] == 16'h0 && a[9:8] != 2'h0;
		vga = io ? (a >= 32'h3b0 && a <= 32'h3bb) ||
			(a >= 32'h3c0 && a <= 32'h3df) : (a >= 32'ha0000 && a <= 32'hbffff);
		ix = {m_lb[31:1], 1'b0};
		qv <= 1'b1;
		qio <= io;
		qa <= a;
		@(posedge i_clk_sys);
		qv <= 1'b0;
		#1;
		chk({27'h0, q_done, q_fwd, q_vga, q_idx, q_dat}, {27'h0, 1'b1, !drop,
			vga && m_bc[3], io && a == ix, io && a == ix + 32'h1});
		if (drop)
			m_st[3] = 1'b1;
		// Return on an edge so the next request is driven there
		@(posedge i_clk_sys);
	endtask : qry
	task automatic ev(input int k, input logic [3:0] len);
		int nta, nse, npe;
		logic xta, xse, xpe;
		xta = k == 0 && m_bc[5];
		xse = (k == 0) ? m_bc[5] && serr_en : k == 1 && m_bc[1];
		xpe = k == 2 && m_bc[0];
		nta = 0;
		nse = 0;
		npe = 0;
		do_ab <= k == 0;
		do_se <= k == 1;
		do_pe <= k == 2;
		se_len <= len;
		@(posedge i_clk_sys);
		do_ab <= 1'b0;
		do_se <= 1'b0;
		do_pe <= 1'b0;
		repeat (14) begin
			@(posedge i_clk_sys);
			nta += (ta === 1'b1);
			nse += (pserr === 1'b1);
			npe += (cperr === 1'b1);
		end
		m_st[k] = 1'b1;
		chk({8'(nta), 8'(nse), 8'(npe), 8'h0},
			{7'h0, xta, 7'h0, xse, 7'h0, xpe, 8'h0});
		chk({31'h0, irq}, {31'h0, |(m_st & m_mask)});
	endtask : ev
	task automatic do_reset;
		i_rst_b <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		m_bc = 16'h0340;
		m_sv = 16'h0;
		m_ss = 16'h0;
		m_lb = 32'h1;
		m_mode = 2'h3;
		m_we = 1'b1;
		m_st = 4'h0;
		m_mask = 4'h0;
	endtask : do_reset
	// --------
	// Sequence
	// --------
	initial begin
		do_reset();
		foreach (regs[i]) rc(regs[i]);
		outs();
		wr(32'hf8, 32'hffffffff);
		rc(32'hf8);
		outs();
		for (int i = 0; i < 6; i++) begin
			wr(32'hf8, $random(seed));
			rc(32'hf8);
			outs();
		end
		for (int m = 0; m < 4; m++) begin
			wr(32'h140, 32'(m) << 1);
			rc(32'hf4);
		end
		wr(32'hf4, 32'hffffffff);
		wr(32'h1fc, $random(seed));
		rc(32'hf4);
		rc(32'h1fc);
		for (int i = 0; i < 4; i++) begin
			wr(32'h144, (i < 2) ? 32'h20 : 32'h0);
			wr(32'h100, $random(seed));
			wr(32'h108, $random(seed));
			rc(32'h100);
			rc(32'h108);
		end
		for (int i = 0; i < 4; i++) begin
			wr(32'h110, $random(seed));
			rc(32'h110);
			qry(1'b1, {m_lb[31:1], 1'b0});
			qry(1'b1, {m_lb[31:1], 1'b0} + 32'h1);
			qry(1'b0, {m_lb[31:1], 1'b0});
		end
		for (int b = 0; b < 4; b++) begin
			wr(32'hf8, 32'(b) << 2);
			for (int j = 0; j < 16; j++) qry(j[0], qtab[j / 2]);
			rc(32'h148);
		end
		for (int i = 0; i < 12; i++) begin
			wr(32'hf8, i[0] ? 32'h23 : 32'h0);
			serr_en <= i[1];
			wr(32'h14c, i[2] ? 32'hf : 32'h5);
			ev(i % 3, i[1] ? 4'h7 : 4'h3);
			rc(32'h148);
			repeat (2) @(posedge i_clk_sys);
			chk({31'h0, irq}, 32'h0);
		end
		wr(32'hf8, 32'h0);
		outs();
		i_rst_b <= 1'b0;
		#1;
		chk({31'h0, crst_n}, 32'h0);
		do_reset();
		rc(32'hf8);
		outs();
		close_out();
	end
endmodule : cbc_bridge_regs_tb
